// file: adtp_conv_model.sv
// Purpose: behavioural converter core facing the sequencer
// Assumes: one done pulse per start, lat cycles later
// Notes: data lines toggle outside done so stale values never pass
`timescale 1ns/1ps
module adtp_conv_model (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic [3:0] lat,
  input wire adtp_pkg::adtp_conv_req_t convReq,
  output adtp_pkg::adtp_conv_res_t convRes
);
  import adtp_pkg::*;
  logic [3:0] cnt_q = 4'h0;
  logic [4:0] ch_q = 5'h00;
  initial convRes = '0;
  always @(posedge sys_clk)
  begin
    if (convReq.start)
    begin
      cnt_q <= lat;
      ch_q <= convReq.channel;
    end
    else if (!nrst || convReq.abort || cnt_q == 4'h1)
      cnt_q <= 4'h0;
    else if (cnt_q != 4'h0)
      cnt_q <= cnt_q - 4'h1;
    // an aborted conversion never answers
    if (nrst && !convReq.start && !convReq.abort && cnt_q == 4'h1)
      convRes <= {1'b1, ch_q, 7'h15};
    else
      convRes <= {1'b0, ~convRes.data};
  end
endmodule

// file: adtp_params.svh
// Purpose: offsets, field positions, reset values and counts of the converter sequencer
// Assumes: byte addresses on a 32-bit AXI4-Lite register bus
// Notes: definitions only
`ifndef ADTP_PARAMS_SVH
`define ADTP_PARAMS_SVH
`define ADTP_OFF_CLKSEL 8'h00
`define ADTP_OFF_MODE 8'h04
`define ADTP_OFF_MODE3 8'h08
`define ADTP_OFF_MONCTL 8'h0C
`define ADTP_OFF_MONCMP 8'h14
`define ADTP_OFF_RESULT 8'h20
`define ADTP_OFF_PSEL 8'h50
`define ADTP_OFF_PINTS 8'h80
`define ADTP_OFF_PSET 8'hA0
`define ADTP_OFF_TSET 8'hC0
`define ADTP_OFF_SSET 8'hD0
`define ADTP_OFF_ASET 8'hE0
`define ADTP_MODE_EN_BIT 0
`define ADTP_MODE_SWSTART_BIT 1
`define ADTP_MODE_CONST_BIT 2
`define ADTP_MODE_BUSY_BIT 8
`define ADTP_MON_EN_BIT 7
`define ADTP_MON_BIG_BIT 6
`define ADTP_MON_IDX_LSB 0
`define ADTP_MON_CNT_LSB 8
`define ADTP_RES_OVR_BIT 30
`define ADTP_RES_VALID_BIT 31
`define ADTP_SLOT_EN_BIT 7
`define ADTP_SLOT_PHASE_LSB 5
`define ADTP_PINTS_SEL_BIT 0
`define ADTP_PINTS_EN_BIT 1
`define ADTP_CLKSEL_RST 3'h0
`define ADTP_CLKSEL_MAX 3'h4
`define ADTP_MODE3_RST 3'h0
`define ADTP_CH_MAX_A 5'h0E
`define ADTP_CH_MAX_B 5'h10
`define ADTP_NO_SLOT 4'hC
`define ADTP_RESP_OKAY 2'h0
`define ADTP_RESP_SLVERR 2'h2
`endif

// file: adtp_pkg.sv
// Purpose: shared types of the converter sequencer
// Assumes: adtp_params.svh holds the numbers
// Notes: converter core handshake travels as packed structs
package adtp_pkg;
  typedef enum logic [1:0] {ST_IDLE = 2'b01, ST_RUN = 2'b10} adtp_state_t;
  typedef enum logic [3:0] {SRC_MOTOR = 4'b0001, SRC_TIMER = 4'b0010, SRC_SOFT = 4'b0100,
    SRC_CONST = 4'b1000} adtp_src_t;
  typedef struct packed {
    logic start;
    logic abort;
    logic [4:0] channel;
  } adtp_conv_req_t;
  typedef struct packed {
    logic done;
    logic [11:0] data;
  } adtp_conv_res_t;
endpackage

// file: adtp_sequencer.sv
// Purpose: trigger, program and result sequencing for one converter unit
// Assumes: converter core answers each start with one done pulse; triggers are sys_clk pulses
// Notes: registers over AXI4-Lite; conversion clock is an enable pulse from a divider
//
// The AXI4-Lite register port and the address map were decided locally.
`timescale 1ns/1ps
`include "adtp_params.svh"
module adtp_sequencer #(
  parameter bit UNIT_B = 1'b0
) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [7:0] s_axi_araddr,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  input wire logic [11:0] motorTrigger,
  input wire logic timer5StartEvent,
  output adtp_pkg::adtp_conv_req_t convReq,
  input wire adtp_pkg::adtp_conv_res_t convRes,
  output logic convClkEn,
  output logic [1:0] motorProgramDoneIrq,
  output logic timerProgramDoneIrq,
  output logic softwareProgramDoneIrq,
  output logic constantProgramDoneIrq,
  output logic [1:0] monitorMatchIrq
);
  import adtp_pkg::*;

  localparam logic [4:0] CH_MAX = UNIT_B ? `ADTP_CH_MAX_B : `ADTP_CH_MAX_A;

  logic [2:0] clkSelQ;
  logic modeEnQ;
  logic constEnQ;
  logic [2:0] mode3Q;
  logic [15:0] monCtlQ [2];
  logic [11:0] monCmpQ [2];
  logic [11:0] resQ [12];
  logic [11:0] resValidQ;
  logic [11:0] resOvrQ;
  logic [2:0] pselQ [12];
  logic [1:0] pintsQ [6];
  logic [31:0] psetQ [6];
  logic [7:0] tsetQ [12];
  logic [7:0] ssetQ [12];
  logic [7:0] asetQ [12];
  logic swPendQ;
  logic timerPendQ;
  logic [11:0] motorPendQ;

  ////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
    input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++)
    begin
      if (strb[b])
        r[8*b +: 8] = nw[8*b +: 8];
    end
    return r;
  endfunction

  // kind 0 unmapped, idx is the word within the register group
  function automatic logic [4:0] decodeKind(input logic [7:0] a);
    logic [5:0] w;
    w = a[7:2];
    if (w == 6'd0) return 5'd1;
    if (w == 6'd1) return 5'd2;
    if (w == 6'd2) return 5'd3;
    if (w >= 6'd3 && w < 6'd5) return 5'd4;
    if (w >= 6'd5 && w < 6'd7) return 5'd5;
    if (w >= 6'd8 && w < 6'd20) return 5'd6;
    if (w >= 6'd20 && w < 6'd32) return 5'd7;
    if (w >= 6'd32 && w < 6'd38) return 5'd8;
    if (w >= 6'd40 && w < 6'd46) return 5'd9;
    if (w >= 6'd48 && w < 6'd51) return 5'd10;
    if (w >= 6'd52 && w < 6'd55) return 5'd11;
    if (w >= 6'd56 && w < 6'd59) return 5'd12;
    return 5'd0;
  endfunction

  function automatic logic [3:0] decodeIdx(input logic [7:0] a, input logic [4:0] k);
    logic [7:0] base;
    case (k)
      5'd4: base = `ADTP_OFF_MONCTL;
      5'd5: base = `ADTP_OFF_MONCMP;
      5'd6: base = `ADTP_OFF_RESULT;
      5'd7: base = `ADTP_OFF_PSEL;
      5'd8: base = `ADTP_OFF_PINTS;
      5'd9: base = `ADTP_OFF_PSET;
      5'd10: base = `ADTP_OFF_TSET;
      5'd11: base = `ADTP_OFF_SSET;
      5'd12: base = `ADTP_OFF_ASET;
      default: base = 8'h00;
    endcase
    return 4'((a - base) >> 2);
  endfunction

  // first enabled slot at or above from; no slot gives twelve
  function automatic logic [3:0] firstFrom(input logic [11:0] mask, input logic [4:0] from);
    logic [3:0] r;
    r = `ADTP_NO_SLOT;
    for (int i = 11; i >= 0; i--)
    begin
      if (mask[i] && 5'(i) >= from)
        r = 4'(i);
    end
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // slot tables flattened per source

  logic [11:0] tMask, sMask, aMask;
  logic [3:0] pMask [6];
  logic [4:0] tCh [12], sCh [12], aCh [12];
  logic [4:0] pCh [6][4];

  genvar g, h;
  generate
    for (g = 0; g < 12; g++)
    begin : g_slot
      assign tMask[g] = tsetQ[g][`ADTP_SLOT_EN_BIT] && tsetQ[g][4:0] <= CH_MAX;
      assign sMask[g] = ssetQ[g][`ADTP_SLOT_EN_BIT] && ssetQ[g][4:0] <= CH_MAX;
      assign aMask[g] = asetQ[g][`ADTP_SLOT_EN_BIT] && asetQ[g][4:0] <= CH_MAX;
      assign tCh[g] = tsetQ[g][4:0];
      assign sCh[g] = ssetQ[g][4:0];
      assign aCh[g] = asetQ[g][4:0];
    end
    for (g = 0; g < 6; g++)
    begin : g_prog
      for (h = 0; h < 4; h++)
      begin : g_pslot
        // enable, phase tag, input select per byte
        assign pMask[g][h] = psetQ[g][8*h + `ADTP_SLOT_EN_BIT] && psetQ[g][8*h +: 5] <= CH_MAX;
        assign pCh[g][h] = psetQ[g][8*h +: 5];
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // sequencer

  adtp_state_t stateQ, stateD;
  adtp_src_t srcQ, srcD;
  logic [2:0] progQ, progD;
  logic [3:0] slotQ, slotD;
  logic [11:0] curMask, newMask;
  logic [4:0] chD;
  logic startD, abortD, storeD, finishD, launch;
  logic [3:0] motorIdx;
  logic motorNow;
  logic swRestart, timerTake;
  logic [3:0] firstNew, nextCur;

  always_comb
  begin
    motorIdx = 4'h0;
    for (int i = 11; i >= 0; i--)
    begin
      if (motorTrigger[i])
        motorIdx = 4'(i);
    end
  end
  assign motorNow = modeEnQ && (|motorTrigger);

  always_comb
  begin
    case (srcQ)
      // program numbers 6 and 7 have no slot table and run empty
      SRC_MOTOR: curMask = {8'h00, (progQ < 3'd6) ? pMask[progQ] : 4'h0};
      SRC_TIMER: curMask = tMask;
      SRC_SOFT: curMask = sMask;
      default: curMask = aMask;
    endcase
    case (srcD)
      SRC_MOTOR: newMask = {8'h00, (progD < 3'd6) ? pMask[progD] : 4'h0};
      SRC_TIMER: newMask = tMask;
      SRC_SOFT: newMask = sMask;
      default: newMask = aMask;
    endcase
  end

  // walk upward from the slot after the one just stored
  assign nextCur = firstFrom(curMask, 5'(slotQ) + 5'd1);
  assign firstNew = firstFrom(newMask, 5'd0);

  always_comb
  begin
    stateD = stateQ;
    srcD = srcQ;
    progD = progQ;
    slotD = slotQ;
    launch = 1'b0;
    abortD = 1'b0;
    storeD = 1'b0;
    finishD = 1'b0;
    swRestart = 1'b0;
    timerTake = 1'b0;
    case (stateQ)
      ST_IDLE:
      begin
        if (motorNow || (modeEnQ && |motorPendQ))
        begin
          launch = 1'b1;
          srcD = SRC_MOTOR;
          progD = motorNow ? pselQ[motorIdx] : pselQ[firstFrom(motorPendQ, 5'd0)];
        end
        else if (modeEnQ && timerPendQ)
        begin
          launch = 1'b1;
          timerTake = 1'b1;
          srcD = SRC_TIMER;
        end
        else if (modeEnQ && swPendQ)
        begin
          launch = 1'b1;
          srcD = SRC_SOFT;
        end
        else if (modeEnQ && constEnQ)
        begin
          launch = 1'b1;
          srcD = SRC_CONST;
        end
      end
      ST_RUN:
      begin
        if (!modeEnQ)
        begin
          abortD = 1'b1;
          stateD = ST_IDLE;
        end
        else if (motorNow)
        begin
          // abort at once and start the selected program
          abortD = 1'b1;
          launch = 1'b1;
          swRestart = (srcQ == SRC_SOFT);
          srcD = SRC_MOTOR;
          progD = pselQ[motorIdx];
        end
        else if (convRes.done)
        begin
          storeD = 1'b1;
          if (srcQ == SRC_SOFT && timerPendQ)
          begin
            // timer waits only for the running conversion
            launch = 1'b1;
            timerTake = 1'b1;
            swRestart = 1'b1;
            srcD = SRC_TIMER;
          end
          else if (nextCur == `ADTP_NO_SLOT)
          begin
            finishD = 1'b1;
            stateD = ST_IDLE;
          end
          else
            slotD = nextCur;
        end
      end
      default:
        stateD = ST_IDLE;
    endcase
    if (launch)
    begin
      slotD = firstNew;
      stateD = (firstNew == `ADTP_NO_SLOT) ? ST_IDLE : ST_RUN;
    end
  end

  // a program with no enabled slot completes at once
  logic emptyDone;
  assign emptyDone = launch && firstNew == `ADTP_NO_SLOT;
  assign startD = (launch && !emptyDone) || (storeD && !finishD && !launch);

  always_comb
  begin
    case (srcD)
      SRC_MOTOR: chD = pCh[progD][slotD[1:0]];
      SRC_TIMER: chD = tCh[slotD];
      SRC_SOFT: chD = sCh[slotD];
      default: chD = aCh[slotD];
    endcase
  end

  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
    begin
      stateQ <= ST_IDLE;
      srcQ <= SRC_CONST;
      progQ <= 3'h0;
      slotQ <= 4'h0;
      convReq <= '0;
    end
    else
    begin
      stateQ <= stateD;
      srcQ <= srcD;
      progQ <= progD;
      slotQ <= slotD;
      convReq.start <= startD;
      convReq.abort <= abortD;
      convReq.channel <= startD ? chD : convReq.channel;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // pending triggers; a new event wins over the clear

  logic swStartWr;
  always_ff @(posedge sys_clk)
  begin
    if (!nrst || !modeEnQ)
    begin
      swPendQ <= 1'b0;
      timerPendQ <= 1'b0;
      motorPendQ <= 12'h000;
    end
    else
    begin
      timerPendQ <= timer5StartEvent || (timerPendQ && !timerTake);
      // software start, and restart after preemption
      swPendQ <= swStartWr || swRestart || (swPendQ && !(launch && srcD == SRC_SOFT));
      if (stateQ == ST_IDLE && !motorNow && |motorPendQ)
        motorPendQ <= motorPendQ & ~(12'h001 << firstFrom(motorPendQ, 5'd0));
      else if (motorNow)
        motorPendQ <= motorPendQ | (motorTrigger & ~(12'h001 << motorIdx));
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // end-of-program interrupts, one registered cycle per program end

  logic doneAny;
  adtp_src_t doneSrc;
  logic [2:0] doneProg;
  assign doneAny = finishD || emptyDone;
  assign doneSrc = finishD ? srcQ : srcD;
  assign doneProg = finishD ? progQ : progD;

  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
    begin
      motorProgramDoneIrq <= 2'b00;
      timerProgramDoneIrq <= 1'b0;
      softwareProgramDoneIrq <= 1'b0;
      constantProgramDoneIrq <= 1'b0;
    end
    else
    begin
      // motor program interrupt, chosen and enabled per program
      motorProgramDoneIrq <= (doneAny && doneSrc == SRC_MOTOR && doneProg < 3'd6
        && pintsQ[doneProg][`ADTP_PINTS_EN_BIT])
        ? (2'b01 << pintsQ[doneProg][`ADTP_PINTS_SEL_BIT]) : 2'b00;
      timerProgramDoneIrq <= doneAny && doneSrc == SRC_TIMER;
      softwareProgramDoneIrq <= doneAny && doneSrc == SRC_SOFT;
      constantProgramDoneIrq <= doneAny && doneSrc == SRC_CONST;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // conversion clock divider

  logic [15:0] divCntQ;
  logic [2:0] selEff;
  logic [15:0] divLimit;
  assign selEff = (clkSelQ > `ADTP_CLKSEL_MAX) ? `ADTP_CLKSEL_MAX : clkSelQ;
  assign divLimit = (16'h0001 << selEff) - 16'h0001;

  // enable pulse every 2 to the select sys_clk cycles, a select above 4 taken as 4
  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
    begin
      divCntQ <= 16'h0000;
      convClkEn <= 1'b0;
    end
    else
    begin
      convClkEn <= (divCntQ >= divLimit);
      divCntQ <= (divCntQ >= divLimit) ? 16'h0000 : divCntQ + 16'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // result store and monitors

  logic rdTake;
  logic [4:0] rdKind;
  logic [3:0] rdIdx;
  assign rdKind = decodeKind(s_axi_araddr);
  assign rdIdx = decodeIdx(s_axi_araddr, rdKind);
  logic storeQ;
  logic [3:0] storeIdxQ;

  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
    begin
      resValidQ <= 12'h000;
      resOvrQ <= 12'h000;
      storeQ <= 1'b0;
      storeIdxQ <= 4'h0;
      for (int i = 0; i < 12; i++)
        resQ[i] <= 12'h000;
    end
    else
    begin
      storeQ <= storeD;
      storeIdxQ <= slotQ;
      for (int i = 0; i < 12; i++)
      begin
        logic hitRd;
        logic hitSt;
        hitRd = rdTake && rdKind == 5'd6 && rdIdx == 4'(i);
        // slot m lands in result m
        hitSt = storeD && slotQ == 4'(i);
        if (hitSt)
          resQ[i] <= convRes.data;
        // overwrite of unread sets overrun; read clears, store wins for valid but not for overrun
        resValidQ[i] <= hitSt || (resValidQ[i] && !hitRd);
        resOvrQ[i] <= (hitSt && resValidQ[i] && !hitRd) || (resOvrQ[i] && !hitRd);
      end
    end
  end

  logic [3:0] monCntQ [2];
  generate
    for (g = 0; g < 2; g++)
    begin : g_mon
      logic hit;
      logic match;
      assign hit = storeQ && monCtlQ[g][`ADTP_MON_EN_BIT] && storeIdxQ == monCtlQ[g][3:0];
      assign match = monCtlQ[g][`ADTP_MON_BIG_BIT] ? (resQ[storeIdxQ] >= monCmpQ[g])
        : (resQ[storeIdxQ] < monCmpQ[g]);
      // compare the stored value; count consecutive matches
      always_ff @(posedge sys_clk)
      begin
        if (!nrst)
        begin
          monCntQ[g] <= 4'h0;
          monitorMatchIrq[g] <= 1'b0;
        end
        else
        begin
          monitorMatchIrq[g] <= 1'b0;
          if (hit && !match)
            monCntQ[g] <= 4'h0;
          else if (hit && monCntQ[g] >= monCtlQ[g][11:8])
          begin
            monCntQ[g] <= 4'h0;
            monitorMatchIrq[g] <= 1'b1;
          end
          else if (hit)
            monCntQ[g] <= monCntQ[g] + 4'h1;
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave: write when address and data are both present

  logic wrTake;
  logic [4:0] wrKind;
  logic [3:0] wrIdx;
  assign wrTake = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
  assign s_axi_awready = wrTake;
  assign s_axi_wready = wrTake;
  assign wrKind = decodeKind(s_axi_awaddr);
  assign wrIdx = decodeIdx(s_axi_awaddr, wrKind);
  assign swStartWr = wrTake && wrKind == 5'd2 && s_axi_wstrb[0]
    && s_axi_wdata[`ADTP_MODE_SWSTART_BIT];
  assign rdTake = s_axi_arvalid && !s_axi_rvalid;
  assign s_axi_arready = rdTake;

  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
    begin
      clkSelQ <= `ADTP_CLKSEL_RST;
      modeEnQ <= 1'b0;
      constEnQ <= 1'b0;
      mode3Q <= `ADTP_MODE3_RST;
      for (int i = 0; i < 2; i++)
      begin
        monCtlQ[i] <= 16'h0000;
        monCmpQ[i] <= 12'h000;
      end
      for (int i = 0; i < 12; i++)
      begin
        pselQ[i] <= 3'h0;
        tsetQ[i] <= 8'h00;
        ssetQ[i] <= 8'h00;
        asetQ[i] <= 8'h00;
      end
      for (int i = 0; i < 6; i++)
      begin
        pintsQ[i] <= 2'h0;
        psetQ[i] <= 32'h0000_0000;
      end
    end
    else if (wrTake)
    begin
      case (wrKind)
        5'd1: clkSelQ <= 3'(merge({29'h0, clkSelQ}, s_axi_wdata, s_axi_wstrb));
        5'd2:
        begin
          modeEnQ <= 1'(merge({31'h0, modeEnQ}, s_axi_wdata, s_axi_wstrb) >> `ADTP_MODE_EN_BIT);
          constEnQ <= 1'(merge({29'h0, constEnQ, 2'h0}, s_axi_wdata,
            s_axi_wstrb) >> `ADTP_MODE_CONST_BIT);
        end
        5'd3: mode3Q <= 3'(merge({29'h0, mode3Q}, s_axi_wdata, s_axi_wstrb));
        5'd4: monCtlQ[wrIdx[0]] <= 16'(merge({16'h0, monCtlQ[wrIdx[0]]}, s_axi_wdata,
          s_axi_wstrb));
        5'd5: monCmpQ[wrIdx[0]] <= 12'(merge({20'h0, monCmpQ[wrIdx[0]]}, s_axi_wdata,
          s_axi_wstrb));
        5'd7: pselQ[wrIdx] <= 3'(merge({29'h0, pselQ[wrIdx]}, s_axi_wdata, s_axi_wstrb));
        5'd8: pintsQ[wrIdx[2:0]] <= 2'(merge({30'h0, pintsQ[wrIdx[2:0]]}, s_axi_wdata,
          s_axi_wstrb));
        5'd9: psetQ[wrIdx[2:0]] <= merge(psetQ[wrIdx[2:0]], s_axi_wdata, s_axi_wstrb);
        5'd10, 5'd11, 5'd12:
        begin
          for (int b = 0; b < 4; b++)
          begin
            if (s_axi_wstrb[b] && wrKind == 5'd10)
              tsetQ[4*wrIdx + b] <= s_axi_wdata[8*b +: 8];
            if (s_axi_wstrb[b] && wrKind == 5'd11)
              ssetQ[4*wrIdx + b] <= s_axi_wdata[8*b +: 8];
            if (s_axi_wstrb[b] && wrKind == 5'd12)
              asetQ[4*wrIdx + b] <= s_axi_wdata[8*b +: 8];
          end
        end
        default: ;
      endcase
    end
  end

  logic [31:0] rdVal;
  always_comb
  begin
    case (rdKind)
      5'd1: rdVal = {29'h0, clkSelQ};
      5'd2: rdVal = {23'h0, stateQ == ST_RUN, 5'h0, constEnQ, 1'b0, modeEnQ};
      5'd3: rdVal = {29'h0, mode3Q};
      5'd4: rdVal = {16'h0, monCtlQ[rdIdx[0]]};
      5'd5: rdVal = {20'h0, monCmpQ[rdIdx[0]]};
      5'd6: rdVal = {resValidQ[rdIdx], resOvrQ[rdIdx], 18'h0, resQ[rdIdx]};
      5'd7: rdVal = {29'h0, pselQ[rdIdx]};
      5'd8: rdVal = {30'h0, pintsQ[rdIdx[2:0]]};
      5'd9: rdVal = psetQ[rdIdx[2:0]];
      5'd10: rdVal = {tsetQ[4*rdIdx+3], tsetQ[4*rdIdx+2], tsetQ[4*rdIdx+1], tsetQ[4*rdIdx]};
      5'd11: rdVal = {ssetQ[4*rdIdx+3], ssetQ[4*rdIdx+2], ssetQ[4*rdIdx+1], ssetQ[4*rdIdx]};
      5'd12: rdVal = {asetQ[4*rdIdx+3], asetQ[4*rdIdx+2], asetQ[4*rdIdx+1], asetQ[4*rdIdx]};
      default: rdVal = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `ADTP_RESP_OKAY;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= `ADTP_RESP_OKAY;
      s_axi_rdata <= 32'h0000_0000;
    end
    else
    begin
      if (wrTake)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (wrKind == 5'd0) ? `ADTP_RESP_SLVERR : `ADTP_RESP_OKAY;
      end
      else if (s_axi_bready)
        s_axi_bvalid <= 1'b0;
      if (rdTake)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rdVal;
        s_axi_rresp <= (rdKind == 5'd0) ? `ADTP_RESP_SLVERR : `ADTP_RESP_OKAY;
      end
      else if (s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end
endmodule

// file: adtp_sequencer_assertions.sv
// Purpose: port-level checks of the converter sequencer
// Assumes: one clock, synchronous active-low reset
// Notes: bound to every adtp_sequencer instance
`timescale 1ns/1ps
module adtp_sequencer_assertions
  import adtp_pkg::*;
(
  input wire logic sys_clk, nrst, s_axi_awvalid, s_axi_wvalid, s_axi_awready, s_axi_bvalid,
  input wire logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready,
  input wire logic [1:0] s_axi_bresp, monitorMatchIrq,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [11:0] motorTrigger,
  input wire logic softwareProgramDoneIrq,
  input wire adtp_pkg::adtp_conv_req_t convReq,
  input wire adtp_pkg::adtp_conv_res_t convRes
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  ////////////////////
  property p_wrAns; s_axi_awvalid && s_axi_wvalid && s_axi_awready |=> s_axi_bvalid; endproperty
  a_wrAns: assert property (p_wrAns) else $error("write answer late");
  property p_rdAns; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
  a_rdAns: assert property (p_rdAns) else $error("read answer late");
  property p_bHold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_bHold: assert property (p_bHold) else $error("write response dropped");
  property p_rHold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_rHold: assert property (p_rHold) else $error("read data dropped");
  property p_rdy; s_axi_awready |-> s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid; endproperty
  a_rdy: assert property (p_rdy) else $error("write accepted alone");
  property p_mon; |monitorMatchIrq |-> $past(convRes.done, 2); endproperty
  a_mon: assert property (p_mon) else $error("monitor irq without stored result");
  property p_start; convReq.start |=> !convReq.start || convReq.abort; endproperty
  a_start: assert property (p_start) else $error("start while converting");
  // a disabling write lands one cycle before the abort is computed
  property p_abort; convReq.abort |-> $past(|motorTrigger) || $past(s_axi_wvalid, 2); endproperty
  a_abort: assert property (p_abort) else $error("abort without cause");
  property p_swIrq; softwareProgramDoneIrq |=> !softwareProgramDoneIrq; endproperty
  a_swIrq: assert property (p_swIrq) else $error("software irq not a pulse");
endmodule
bind adtp_sequencer adtp_sequencer_assertions adtp_sequencer_assertions_i (.*);

// file: adtp_sequencer_tb.sv
// Purpose: self-checking bench of the converter sequencer
// Assumes: AXI4-Lite master tasks, reads checked from a queue
// Notes: results carry channel code in data, so slot to result mapping shows
`timescale 1ns/1ps
module adtp_sequencer_tb;
  import adtp_pkg::*;
  logic sys_clk = 0, nrst = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0, timer5StartEvent = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, convClkEn;
  logic timerProgramDoneIrq, softwareProgramDoneIrq, constantProgramDoneIrq;
  logic [1:0] s_axi_bresp, s_axi_rresp, motorProgramDoneIrq, monitorMatchIrq;
  logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, seed = 32'h32cb_bb14;
  logic [3:0] s_axi_wstrb = 4'hF, lat = 4'h1;
  logic [11:0] motorTrigger = 0;
  logic [4:0] ch [4];
  logic [33:0] q [$];
  adtp_conv_req_t convReq;
  adtp_conv_res_t convRes;
  int err_count = 0, num_checks = 0;
  adtp_sequencer adtp_sequencer_i (.*);
  adtp_conv_model adtp_conv_model_i (.*);
  always #25 sys_clk = ~sys_clk;
  ////////////////////
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  function automatic logic pick(input int k);
    case (k)
      0: return s_axi_awready;
      1: return s_axi_bvalid;
      2: return s_axi_arready;
      3: return s_axi_rvalid;
      4: return softwareProgramDoneIrq;
      5: return timerProgramDoneIrq;
      6: return motorProgramDoneIrq[0];
      7: return monitorMatchIrq[0];
      8: return convClkEn;
      default: return constantProgramDoneIrq;
    endcase
  endfunction
  task conclude;
    $display("err_count=%0d num_checks=%0d", err_count, num_checks);
    if (err_count == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task chk(input string n, input logic [33:0] s, input logic [33:0] e);
    num_checks++;
    if (s !== e)
    begin
      err_count++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask
  // bounded wait, sampled between edges so the taking edge is the next rising one
  task w8(input int k);
    int n;
    n = 0;
    do @(negedge sys_clk); while (pick(k) !== 1'b1 && ++n < 300);
    chk("wait", {33'h0, pick(k)}, 34'h1);
    if (pick(k) !== 1'b1) conclude;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    {s_axi_awvalid, s_axi_wvalid, s_axi_awaddr, s_axi_wdata} <= {2'b11, a, d};
    w8(0);
    @(posedge sys_clk);
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b001;
    w8(1);
    chk("bresp", {32'h0, s_axi_bresp}, 34'h0);
    @(posedge sys_clk);
    s_axi_bready <= 0;
  endtask
  task rd(input logic [7:0] a, input logic [33:0] e);
    q.push_back(e);
    @(posedge sys_clk);
    {s_axi_arvalid, s_axi_araddr} <= {1'b1, a};
    w8(2);
    @(posedge sys_clk);
    {s_axi_arvalid, s_axi_rready} <= 2'b01;
    w8(3);
    @(posedge sys_clk);
    s_axi_rready <= 0;
  endtask
  function automatic logic [33:0] res(input logic [1:0] f, input logic [4:0] c);
    return {2'h0, f, 18'h0, c, 7'h15};
  endfunction
  always @(posedge sys_clk)
    if (s_axi_rvalid && s_axi_rready)
      chk("read", {s_axi_rresp, s_axi_rdata}, q.pop_front());
  ////////////////////
  initial
  begin
    repeat (16) @(posedge sys_clk);
    nrst <= 1;
    for (int i = 0; i < 4; i++)
    begin
      seed = xs(seed);
      ch[i] = 5'(seed % 15);
    end
    wr(8'h00, 32'h0000_0001);
    // select one divides by two once the new value settles
    w8(8);
    @(negedge sys_clk) chk("clken", {33'h0, convClkEn}, 34'h0);
    @(negedge sys_clk) chk("clken", {33'h0, convClkEn}, 34'h1);
    wr(8'h08, 32'h0000_0004);
    wr(8'h04, 32'h0000_0001);
    wr(8'hD0, {1'b1, 2'b0, ch[3], 8'h00, 1'b1, 2'b0, ch[1], 1'b1, 2'b0, ch[0]});
    wr(8'h0C, 32'h0000_0080);
    wr(8'h14, 32'h0000_0FFF);
    wr(8'h04, 32'h0000_0003);
    w8(7);
    w8(4);
    lat <= 4'h5;
    wr(8'h04, 32'h0000_0003);
    w8(4);
    for (int i = 0; i < 4; i++)
      if (i != 2) rd(8'h20 + 8'(4 * i), res(2'b11, ch[i]));
    rd(8'h28, 34'h0);
    rd(8'h20, res(2'b00, ch[0]));
    wr(8'hC0, {24'h0, 1'b1, 2'b0, ch[2]});
    @(posedge sys_clk) timer5StartEvent <= 1;
    @(posedge sys_clk) timer5StartEvent <= 0;
    w8(5);
    rd(8'h20, res(2'b10, ch[2]));
    wr(8'h50, 32'h0000_0000);
    wr(8'h80, 32'h0000_0002);
    wr(8'hA0, {24'h0, 1'b1, 2'b01, ch[1]});
    wr(8'h04, 32'h0000_0003);
    @(posedge sys_clk) motorTrigger <= 12'h001;
    @(posedge sys_clk) motorTrigger <= 12'h000;
    w8(6);
    w8(4);
    rd(8'h20, res(2'b11, ch[0]));
    rd(8'h24, res(2'b10, ch[1]));
    wr(8'h04, 32'h0000_0003);
    @(posedge sys_clk) timer5StartEvent <= 1;
    @(posedge sys_clk) timer5StartEvent <= 0;
    w8(5);
    w8(4);
    // result 0 is left unread, so the constant store overruns it
    wr(8'hE0, {24'h0, 1'b1, 2'b0, ch[3]});
    wr(8'h04, 32'h0000_0005);
    w8(9);
    wr(8'h04, 32'h0000_0000);
    rd(8'h20, res(2'b11, ch[3]));
    rd(8'hF0, {2'h2, 32'h0000_0000});
    conclude;
  end
endmodule
